// ### icas_scaler.v
// icas_scaler.v: input characteristic, point table editor and analogue output scaler
`timescale 1ns/1ps
`include "icas_defs.vh"

module icas_scaler #(
	parameter [26:0] SHOW_CYC = `ICAS_SHOW_CYC,
	parameter [26:0] LONG_CYC = `ICAS_LONG_CYC
) (
	// clock and reset
	input  wire               mclk,
	input  wire               rst,
	// measurement front end
	input  wire signed [15:0] inRaw,
	input  wire        [3:0]  inType,
	// input configuration
	input  wire        [1:0]  convShape,
	input  wire        [9:0]  lowExtensionPct,
	input  wire        [9:0]  highExtensionPct,
	input  wire signed [15:0] paramValue,
	input  wire               setLowStb,
	input  wire               setHighStb,
	input  wire               dpEditActive,
	// panel keys, asynchronous pins
	input  wire               keyUpPin,
	input  wire               keyDownPin,
	input  wire               keyEnterPin,
	// point menu
	input  wire               pointAddFunc,
	input  wire               pointDeleteFunc,
	input  wire               pointEditFunc,
	input  wire               pointAbort,
	input  wire               pointStore,
	input  wire signed [15:0] pointX,
	input  wire signed [15:0] pointY,
	// output configuration
	input  wire        [1:0]  outputSourceSel,
	input  wire        [2:0]  outMode,
	input  wire        [1:0]  outVariant,
	input  wire signed [15:0] outputLowPoint,
	input  wire signed [15:0] outputHighPoint,
	input  wire        [9:0]  outLowExtPct,
	input  wire        [9:0]  outHighExtPct,
	input  wire        [2:0]  outputAlarmSel,
	input  wire signed [15:0] busValue,
	input  wire signed [15:0] pidOut,
	// display results
	output reg  signed [15:0] displayValue,
	output reg         [1:0]  decimalPos,
	output reg                underRangeWarning,
	output reg                overRangeWarning,
	output reg                displayOverflowWarning,
	output reg                tableErrorWarning,
	output reg                generalErrorWarning,
	output reg  signed [15:0] displayLowValue,
	output reg  signed [15:0] displayHighValue,
	// point editor
	output reg         [4:0]  pointCount,
	output wire               showPointCount,
	output wire               deleteConfirmPrompt,
	output wire               coordEditActive,
	output reg                showCoordY,
	output reg         [4:0]  selIndex,
	output reg  signed [15:0] selX,
	output reg  signed [15:0] selY,
	// analogue output
	output reg         [15:0] aoutValue,
	output reg                aoutEnable,
	output reg                criticalAlarm
);

	localparam [5:0] ST_IDLE  = 6'h01;
	localparam [5:0] ST_COUNT = 6'h02;
	localparam [5:0] ST_SEL   = 6'h04;
	localparam [5:0] ST_CONF  = 6'h08;
	localparam [5:0] ST_EDIT  = 6'h10;
	localparam [5:0] ST_INS   = 6'h20;

	// sign extension to the working width
	function signed [31:0] sx;
		input [15:0] v;
		begin
			sx = {{16{v[15]}}, v};
		end
	endfunction

	// zero extension of a percentage setting
	function signed [31:0] ux;
		input [9:0] v;
		begin
			ux = {22'h00_0000, v};
		end
	endfunction

	// limit a display parameter to its legal span
	function signed [15:0] clampDisp;
		input signed [15:0] v;
		begin
			if (v < `ICAS_DISP_MIN)
				clampDisp = `ICAS_DISP_MIN;
			else if (v > `ICAS_DISP_MAX)
				clampDisp = `ICAS_DISP_MAX;
			else
				clampDisp = v;
		end
	endfunction

	// bitwise integer square root, one trial per result bit
	function [10:0] isqrt;
		input [21:0] v;
		reg   [10:0] root;
		reg   [10:0] trial;
		integer      b;
		begin
			root = 11'h000;
			for (b = 10; b >= 0; b = b - 1) begin
				trial = root | (11'h001 << b);
				if ({11'h000, trial} * {11'h000, trial} <= v)
					root = trial;
			end
			isqrt = root;
		end
	endfunction

	reg        [5:0]  st_ff;
	reg        [26:0] tmr_ff;
	reg               delMode_ff;
	reg               long_ff;
	reg signed [15:0] pX_ff;
	reg signed [15:0] pY_ff;
	reg signed [15:0] lo_ff;
	reg signed [15:0] hi_ff;
	reg signed [15:0] ptX_ff [0:`ICAS_MAXP-1];
	reg signed [15:0] ptY_ff [0:`ICAS_MAXP-1];
	reg        [2:0]  ks1_ff;
	reg        [2:0]  ks2_ff;
	reg        [2:0]  ks3_ff;
	reg        [2:0]  kst_ff;
	reg        [2:0]  kpv_ff;

	// keys pass three flops; a level counts once the last two agree
	wire [2:0] keyPins = {keyEnterPin, keyDownPin, keyUpPin};
	wire [2:0] nxt_kst = (ks2_ff & ks3_ff) | (kst_ff & (ks2_ff | ks3_ff));
	wire [2:0] kRise   = kst_ff & ~kpv_ff;
	wire       entFall = ~kst_ff[2] & kpv_ff[2];

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ks1_ff <= 3'h0;
			ks2_ff <= 3'h0;
			ks3_ff <= 3'h0;
			kst_ff <= 3'h0;
			kpv_ff <= 3'h0;
		end else begin
			ks1_ff <= keyPins;
			ks2_ff <= ks1_ff;
			ks3_ff <= ks2_ff;
			kst_ff <= nxt_kst;
			kpv_ff <= kst_ff;
		end
	end

	wire       isUser   = (convShape == `ICAS_SH_USER);
	wire       liveZero = (inType == `ICAS_IN_4_20) | (inType == `ICAS_IN_1_5) |
	                      (inType == `ICAS_IN_2_10);
	wire [9:0] loExt    = (lowExtensionPct > `ICAS_IN_LO_MAX) ? `ICAS_IN_LO_MAX : lowExtensionPct;
	wire [9:0] hiExt    = (highExtensionPct > `ICAS_IN_HI_MAX) ? `ICAS_IN_HI_MAX : highExtensionPct;

	// measurement path: borders, shape, table interpolation
	reg signed [31:0] raw, loB, hiB, frac, g, rv, disp, res, x0, x1, y0, y1;
	reg               under, over;
	integer           i, seg;
	always @* begin
		raw   = sx(inRaw);
		loB   = liveZero ? (`ICAS_LZ_START - ux(loExt) / `ICAS_LZ_DIV) : 32'sh0000_0000;
		hiB   = `ICAS_FULL + ux(hiExt);
		under = raw < loB;
		over  = raw > hiB;
		frac  = liveZero ? (((raw - `ICAS_LZ_START) * `ICAS_LZ_MUL) >>> `ICAS_LZ_SHR) : raw;
		rv    = (frac > 0) ? frac * `ICAS_FULL : 32'sh0000_0000;
		case (convShape)
			`ICAS_SH_SQR:  g = (frac * ((frac < 0) ? -frac : frac)) / `ICAS_FULL;
			`ICAS_SH_ROOT: g = {21'h00_0000, isqrt(rv[21:0])};
			default:       g = frac;
		endcase
		disp = sx(lo_ff) + ((sx(hi_ff) - sx(lo_ff)) * g) / `ICAS_FULL;
		// segment search relies on the table being kept sorted by X
		seg = 0;
		for (i = 1; i < `ICAS_MAXP - 1; i = i + 1)
			if ((i + 1 < pointCount) && (sx(ptX_ff[i]) <= frac))
				seg = i;
		x0 = sx(ptX_ff[seg]);
		x1 = sx(ptX_ff[seg + 1]);
		y0 = sx(ptY_ff[seg]);
		y1 = sx(ptY_ff[seg + 1]);
		if (isUser)
			res = (x1 == x0) ? y0 : y0 + ((y1 - y0) * (frac - x0)) / (x1 - x0);
		else
			res = disp;
	end

	// insert position and duplicate search for a new point
	wire              editing = st_ff[4];
	wire signed [15:0] insX   = st_ff[5] ? pX_ff : pointX;
	wire signed [15:0] insY   = st_ff[5] ? pY_ff : pointY;
	reg        [4:0]  insPos;
	reg               dupHit;
	integer           j;
	always @* begin
		insPos = 5'h00;
		dupHit = (pointX < `ICAS_X_MIN) | (pointX > `ICAS_X_MAX);
		for (j = 0; j < `ICAS_MAXP; j = j + 1)
			if (j < pointCount) begin
				if (ptX_ff[j] < insX)
					insPos = insPos + 5'h01;
				if ((ptX_ff[j] == pointX) && !(editing && (j == selIndex)))
					dupHit = 1'b1;
			end
	end

	wire full    = (pointCount == `ICAS_MAXP);
	wire addReq  = st_ff[0] & pointAddFunc & isUser;
	wire doAdd   = addReq & ~dupHit & ~full & ~pointAbort;
	wire doStore = editing & pointStore & ~dupHit & ~pointAbort & isUser;
	wire doIns   = doAdd | (st_ff[5] & ~pointAbort & isUser); // abort keeps count and table alike
	wire doDel   = (st_ff[3] & kRise[2] & ~pointAbort & isUser) | doStore;
	wire ptErr   = (addReq & (dupHit | full)) | (editing & pointStore & dupHit);
	wire ptCmd   = pointAddFunc | pointDeleteFunc | pointEditFunc;

	assign showPointCount      = st_ff[1];
	assign deleteConfirmPrompt = st_ff[3];
	assign coordEditActive     = st_ff[4];

	// point storage: sorted insert, shift-down delete
	integer k;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (k = 0; k < `ICAS_MAXP; k = k + 1) begin
				ptX_ff[k] <= 16'h0000;
				ptY_ff[k] <= 16'h0000;
			end
		end else if (doIns) begin
			for (k = 1; k < `ICAS_MAXP; k = k + 1)
				if (k > insPos) begin
					ptX_ff[k] <= ptX_ff[k - 1];
					ptY_ff[k] <= ptY_ff[k - 1];
				end
			ptX_ff[insPos] <= insX;
			ptY_ff[insPos] <= insY;
		end else if (doDel) begin
			for (k = 0; k < `ICAS_MAXP - 1; k = k + 1)
				if (k >= selIndex) begin
					ptX_ff[k] <= ptX_ff[k + 1];
					ptY_ff[k] <= ptY_ff[k + 1];
				end
		end
	end

	// point editor sequence; an edit is a delete followed by a sorted insert
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_ff       <= ST_IDLE;
			tmr_ff      <= 27'h000_0000;
			delMode_ff  <= 1'b0;
			long_ff     <= 1'b0;
			showCoordY  <= 1'b0;
			selIndex    <= 5'h00;
			pointCount  <= 5'h00;
			pX_ff       <= 16'h0000;
			pY_ff       <= 16'h0000;
			generalErrorWarning <= 1'b0;
		end else begin
			if (ptErr)
				generalErrorWarning <= 1'b1;
			else if (ptCmd)
				generalErrorWarning <= 1'b0;
			if (pointAbort | ~isUser) begin
				st_ff <= ST_IDLE;
			end else begin
				case (st_ff)
					ST_IDLE: begin
						if (doAdd)
							pointCount <= pointCount + 5'h01;
						if (isUser & (pointDeleteFunc | pointEditFunc)) begin
							delMode_ff <= pointDeleteFunc;
							tmr_ff     <= 27'h000_0000;
							st_ff      <= ST_COUNT;
						end
					end
					ST_COUNT: begin
						if (tmr_ff == SHOW_CYC - 27'h000_0001) begin
							tmr_ff     <= 27'h000_0000;
							selIndex   <= 5'h00;
							showCoordY <= 1'b0;
							long_ff    <= 1'b0;
							st_ff      <= (pointCount == 5'h00) ? ST_IDLE : ST_SEL;
						end else begin
							tmr_ff <= tmr_ff + 27'h000_0001;
						end
					end
					ST_SEL: begin
						if (kRise[0] && (selIndex + 5'h01 < pointCount))
							selIndex <= selIndex + 5'h01;
						else if (kRise[1] && (selIndex != 5'h00))
							selIndex <= selIndex - 5'h01;
						if (kst_ff[2] & ~long_ff) begin
							if (tmr_ff == LONG_CYC - 27'h000_0001) begin
								long_ff <= 1'b1;
								st_ff   <= delMode_ff ? ST_CONF : ST_EDIT;
							end else begin
								tmr_ff <= tmr_ff + 27'h000_0001;
							end
						end else if (~kst_ff[2]) begin
							tmr_ff  <= 27'h000_0000;
							long_ff <= 1'b0;
							if (entFall & ~long_ff)
								showCoordY <= ~showCoordY;
						end
					end
					ST_CONF: begin
						if (kRise[2]) begin
							pointCount <= pointCount - 5'h01;
							tmr_ff     <= 27'h000_0000;
							st_ff      <= ST_COUNT;
						end
					end
					ST_EDIT: begin
						if (doStore) begin
							pointCount <= pointCount - 5'h01;
							pX_ff      <= pointX;
							pY_ff      <= pointY;
							st_ff      <= ST_INS;
						end else if (pointStore) begin
							st_ff <= ST_SEL;
						end
					end
					ST_INS: begin
						pointCount <= pointCount + 5'h01;
						selIndex   <= insPos;
						st_ff      <= ST_SEL;
					end
					default: st_ff <= ST_IDLE;
				endcase
			end
		end
	end

	// display parameters, decimal point and measurement results
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			lo_ff                  <= 16'h0000;
			hi_ff                  <= 16'h0000;
			decimalPos             <= 2'h0;
			displayValue           <= 16'h0000;
			underRangeWarning      <= 1'b0;
			overRangeWarning       <= 1'b0;
			displayOverflowWarning <= 1'b0;
			tableErrorWarning      <= 1'b0;
			displayLowValue        <= 16'h0000;
			displayHighValue       <= 16'h0000;
			selX                   <= 16'h0000;
			selY                   <= 16'h0000;
		end else begin
			if (setLowStb & ~isUser)
				lo_ff <= clampDisp(paramValue);
			if (setHighStb & ~isUser)
				hi_ff <= clampDisp(paramValue);
			if (dpEditActive & kRise[0] & (decimalPos != 2'h3))
				decimalPos <= decimalPos + 2'h1;
			else if (dpEditActive & kRise[1] & (decimalPos != 2'h0))
				decimalPos <= decimalPos - 2'h1;
			displayValue           <= res[15:0];
			underRangeWarning      <= under;
			overRangeWarning       <= over;
			displayOverflowWarning <= ~under & ~over &
			                          ((res < sx(`ICAS_DISP_MIN)) | (res > sx(`ICAS_DISP_MAX)));
			tableErrorWarning      <= isUser & (pointCount < `ICAS_MINP);
			if (isUser && (pointCount != 5'h00)) begin
				displayLowValue  <= ptY_ff[0];
				displayHighValue <= ptY_ff[pointCount - 5'h01];
			end else begin
				displayLowValue  <= lo_ff;
				displayHighValue <= hi_ff;
			end
			selX <= ptX_ff[selIndex];
			selY <= ptY_ff[selIndex];
		end
	end

	// output path: source, range, scaling, clamp and alarm level
	wire              isCur = (outVariant != `ICAS_VAR_ACT_V);
	wire       [9:0]  olLim = (outVariant == `ICAS_VAR_PAS_I) ? `ICAS_OL_PAS : `ICAS_OL_ACT;
	wire       [9:0]  ohLim = isCur ? `ICAS_OH_CUR : `ICAS_OH_VOLT;
	wire       [9:0]  olo   = (outLowExtPct > olLim) ? olLim : outLowExtPct;
	wire       [9:0]  ohi   = (outHighExtPct > ohLim) ? ohLim : outHighExtPct;
	reg signed [31:0] w, aA, aB, den, o, oMin, oMax, alm;
	reg               okMode, almHold;
	always @* begin
		case (outputSourceSel)
			`ICAS_SRC_IN:   w = sx(displayValue);
			`ICAS_SRC_BUS:  w = sx(busValue);
			`ICAS_SRC_PIDP: w = (pidOut > 0) ? sx(pidOut) : 32'sh0000_0000;
			default:        w = (pidOut < 0) ? -sx(pidOut) : 32'sh0000_0000;
		endcase
		aA     = 32'sh0000_0000;
		aB     = 32'sh0000_0000;
		okMode = 1'b0;
		case (outMode)
			`ICAS_OM_I4_20: begin aA = `ICAS_L_I4; aB = `ICAS_L_I20; okMode = isCur; end
			`ICAS_OM_I0_20: begin aB = `ICAS_L_I20; okMode = (outVariant == `ICAS_VAR_ACT_I); end
			`ICAS_OM_V0_5:  begin aB = `ICAS_L_V5; okMode = ~isCur; end
			`ICAS_OM_V1_5:  begin aA = `ICAS_L_V1; aB = `ICAS_L_V5; okMode = ~isCur; end
			`ICAS_OM_V0_10: begin aB = `ICAS_L_V10; okMode = ~isCur; end
			`ICAS_OM_V2_10: begin aA = `ICAS_L_V2; aB = `ICAS_L_V10; okMode = ~isCur; end
			default: okMode = 1'b0;
		endcase
		// a reversed pair of points gives a negative slope here
		den  = sx(outputHighPoint) - sx(outputLowPoint);
		o    = (den == 0) ? aA : ((w - sx(outputLowPoint)) * (aB - aA)) / den + aA;
		oMin = aA - (aA * ux(olo)) / `ICAS_FULL;
		oMax = aB + (aB * ux(ohi)) / `ICAS_FULL;
		if (o < oMin)
			o = oMin;
		else if (o > oMax)
			o = oMax;
		almHold = 1'b0;
		case (outputAlarmSel)
			`ICAS_AL_1: alm = isCur ? `ICAS_L_I221 : `ICAS_L_V110;
			`ICAS_AL_2: alm = isCur ? `ICAS_L_I34 : `ICAS_L_V55;
			`ICAS_AL_3: begin
				alm     = isCur ? 32'sh0000_0000 : `ICAS_L_V12;
				almHold = (outVariant == `ICAS_VAR_PAS_I);
			end
			`ICAS_AL_4: begin alm = `ICAS_L_V06; almHold = isCur; end
			`ICAS_AL_5: begin alm = 32'sh0000_0000; almHold = isCur; end
			default:    begin alm = 32'sh0000_0000; almHold = 1'b1; end
		endcase
	end

	// output register; hold freezes the last level while critical
	wire crit = under | over;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			aoutValue     <= 16'h0000;
			aoutEnable    <= 1'b0;
			criticalAlarm <= 1'b0;
		end else begin
			criticalAlarm <= crit;
			aoutEnable    <= okMode;
			if (!okMode)
				aoutValue <= 16'h0000;
			else if (crit & ~almHold)
				aoutValue <= alm[15:0];
			else if (~crit)
				aoutValue <= o[15:0];
		end
	end

endmodule // icas_scaler

// ### icas_defs.vh
// icas_defs.vh: constants of the input characteristic and analogue output scaler
`ifndef ICAS_DEFS_VH
`define ICAS_DEFS_VH
// Summary of operation
// - linear, square, root map onto display span
// - user table holds up to twenty points
// - user table under two points shows error
// - four decimal positions, changed by up/down keys
// - display low/high values limited to -999..9999
// - user table blocks low/high edits, derives them
// - new point: X percent then Y value
// - duplicate X rejected with general error
// - show count, select, short toggle, long act
// - enter again deletes point, count shown again
// - point functions only in user table shape
// - outside permissible range shows under/over warning
// - lower border live-zero minus low extension
// - upper border top plus high extension
// - display beyond -999..9999 shows overflow warning; code: only while no under/over warning
// - output source: input, bus, PID halves
// - output mode limited by hardware variant
// - output linear between low and high points
// - low above high point reverses output
// - output clamped by extended range limits
// - output extensions limited per output variant
// - critical situation forces alarm output level
// - after critical situation computed output returns
// - input outside permissible range is critical

// timing
`define ICAS_CLK_HZ     32'h0262_5a00
`define ICAS_MS_PER_S   32'h0000_03e8
`define ICAS_SHOW_MS    32'h0000_05dc
`define ICAS_LONG_MS    32'h0000_07d0
`define ICAS_SHOW_CYC   27'h393_8700    // count display time in clock cycles
`define ICAS_LONG_CYC   27'h4c4_b400    // long enter press in clock cycles

// fixed point: input and table X in 0.1 % of the nominal range
`define ICAS_FULL       32'sh0000_03e8
`define ICAS_LZ_START   32'sh0000_00c8
`define ICAS_LZ_DIV     32'sh0000_0005
`define ICAS_LZ_MUL     32'sh0000_0005
`define ICAS_LZ_SHR     2'h2
`define ICAS_DISP_MIN   16'shfc19
`define ICAS_DISP_MAX   16'sh270f
`define ICAS_X_MIN      16'shfc19
`define ICAS_X_MAX      16'sh07cf
`define ICAS_MAXP       5'h14
`define ICAS_MINP       5'h02

// extension limits in 0.1 %
`define ICAS_IN_LO_MAX  10'h3e7
`define ICAS_IN_HI_MAX  10'h0c7
`define ICAS_OL_ACT     10'h3e7
`define ICAS_OL_PAS     10'h12b
`define ICAS_OH_CUR     10'h0c7
`define ICAS_OH_VOLT    10'h063

// conversion shapes
`define ICAS_SH_LIN     2'h0
`define ICAS_SH_SQR     2'h1
`define ICAS_SH_ROOT    2'h2
`define ICAS_SH_USER    2'h3

// live-zero input types (others: 0-20 mA 0, 0-5 V 2, 0-10 V 4, mV 6..9)
`define ICAS_IN_4_20    4'h1
`define ICAS_IN_1_5     4'h3
`define ICAS_IN_2_10    4'h5

// output sources, variants, modes
`define ICAS_SRC_IN     2'h0
`define ICAS_SRC_BUS    2'h1
`define ICAS_SRC_PIDP   2'h2
`define ICAS_SRC_PIDN   2'h3
`define ICAS_VAR_ACT_I  2'h0
`define ICAS_VAR_PAS_I  2'h1
`define ICAS_VAR_ACT_V  2'h2
`define ICAS_OM_OFF     3'h0
`define ICAS_OM_I4_20   3'h1
`define ICAS_OM_I0_20   3'h2
`define ICAS_OM_V0_5    3'h3
`define ICAS_OM_V1_5    3'h4
`define ICAS_OM_V0_10   3'h5
`define ICAS_OM_V2_10   3'h6

// output levels in uA or mV
`define ICAS_L_I4       32'sh0000_0fa0
`define ICAS_L_I20      32'sh0000_4e20
`define ICAS_L_V1       32'sh0000_03e8
`define ICAS_L_V2       32'sh0000_07d0
`define ICAS_L_V5       32'sh0000_1388
`define ICAS_L_V10      32'sh0000_2710
`define ICAS_L_I221     32'sh0000_5654
`define ICAS_L_I34      32'sh0000_0d48
`define ICAS_L_V110     32'sh0000_2af8
`define ICAS_L_V55      32'sh0000_157c
`define ICAS_L_V12      32'sh0000_04b0
`define ICAS_L_V06      32'sh0000_0258

// alarm selections
`define ICAS_AL_HOLD    3'h0
`define ICAS_AL_1       3'h1
`define ICAS_AL_2       3'h2
`define ICAS_AL_3       3'h3
`define ICAS_AL_4       3'h4
`define ICAS_AL_5       3'h5
`endif

// ### icas_props.sv
// port checker of the scaler, bound into every instance
`timescale 1ns/1ps
module icas_props #(parameter [26:0] SHOW_CYC = 20, parameter [26:0] LONG_CYC = 30) (
	// clock and reset
	input wire mclk, rst,
	// watched inputs
	input wire signed [15:0] inRaw,
	input wire [3:0] inType,
	input wire [1:0] convShape,
	input wire [9:0] highExtensionPct,
	input wire [2:0] outMode,
	input wire pointAddFunc, pointDeleteFunc,
	// watched outputs
	input wire underRangeWarning, overRangeWarning, displayOverflowWarning,
	input wire tableErrorWarning, generalErrorWarning, criticalAlarm, aoutEnable,
	input wire showPointCount, deleteConfirmPrompt, coordEditActive,
	input wire [4:0] pointCount,
	input wire [15:0] aoutValue
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// editor counts as idle when the count, confirm and edit outputs are all down
	wire idle = !showPointCount && !deleteConfirmPrompt && !coordEditActive;

	chk_over_range: assert property (int'(inRaw) > 1000 + int'(highExtensionPct)
		|=> overRangeWarning) else $error("over range flag missing");
	chk_under_zero: assert property (!(inType inside {4'h1, 4'h3, 4'h5})
		&& inRaw < 0 |=> underRangeWarning) else $error("under range flag missing");
	chk_crit_alarm: assert property (criticalAlarm ==
		(underRangeWarning || overRangeWarning)) else $error("critical flag wrong");
	chk_ovf_alone: assert property (displayOverflowWarning |->
		!underRangeWarning && !overRangeWarning) else $error("overflow with range flag");
	chk_table_err: assert property ((convShape == 2'h3 && pointCount < 5'h02) [*2]
		|-> tableErrorWarning) else $error("table error missing");
	chk_count_max: assert property (pointCount <= 5'h14)
		else $error("point count above limit");
	chk_aout_off: assert property ((outMode == 3'h0 && !criticalAlarm) [*2]
		|-> !aoutEnable && aoutValue == 16'h0000) else $error("output not off");
	chk_add_point: assert property (pointAddFunc && convShape == 2'h3 && idle |=>
		pointCount == $past(pointCount) + 5'h01 || generalErrorWarning)
		else $error("add neither counted nor refused");
	chk_menu_block: assert property (pointDeleteFunc && convShape != 2'h3
		|=> !showPointCount) else $error("point menu outside table shape");

	cover property (overRangeWarning);
	cover property (deleteConfirmPrompt);
	cover property (displayOverflowWarning);
	cover property (coordEditActive);
endmodule // icas_props

bind icas_scaler icas_props #(.SHOW_CYC(SHOW_CYC), .LONG_CYC(LONG_CYC)) u_props (.*);

// ### icas_front_model.sv
// front end and output converter model facing the scaler
`timescale 1ns/1ps
module icas_front_model (
	// clock and reset
	input wire mclk, rst,
	// requested reading and converter command
	input wire signed [15:0] rawReq,
	input wire [15:0] aoutValue,
	input wire aoutEnable,
	output logic signed [15:0] inRaw,
	output logic [15:0] convOut
);
	// reading moves between sampling edges so the scaler never sees it change
	always @(negedge mclk or posedge rst) begin
		if (rst) inRaw <= 16'sh0000;
		else inRaw <= rawReq;
	end
	// a disabled converter delivers nothing
	always @(posedge mclk) begin
		convOut <= aoutEnable ? aoutValue : 16'h0000;
	end
endmodule // icas_front_model

// ### testbench.sv
// self-checking bench of the scaler
`timescale 1ns/1ps
module testbench;
	logic mclk = 0, rst = 1;
	logic signed [15:0] inRaw, rawReq, paramValue, pointX, pointY, outputLowPoint;
	logic signed [15:0] outputHighPoint, busValue, pidOut, displayValue;
	logic signed [15:0] displayLowValue, displayHighValue, selX, selY;
	logic [15:0] aoutValue, convOut;
	logic [9:0] lowExtensionPct, highExtensionPct, outLowExtPct, outHighExtPct;
	logic [4:0] pointCount, selIndex;
	logic [3:0] inType;
	logic [2:0] outMode, outputAlarmSel;
	logic [1:0] convShape, outputSourceSel, outVariant, decimalPos;
	logic setLowStb, setHighStb, dpEditActive, keyUpPin, keyDownPin, keyEnterPin;
	logic pointAddFunc, pointDeleteFunc, pointEditFunc, pointAbort, pointStore;
	logic underRangeWarning, overRangeWarning, displayOverflowWarning, aoutEnable;
	logic tableErrorWarning, generalErrorWarning, showPointCount, criticalAlarm;
	logic deleteConfirmPrompt, coordEditActive, showCoordY;
	int err_total = 0, total_checks = 0, cyc = 0;
	int ev[5];

	icas_scaler #(.SHOW_CYC(27'd20), .LONG_CYC(27'd30)) i_dut (.*);
	icas_front_model i_front (.*);

	always #12.5 mclk = ~mclk;
	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			conclude();
		end
	end

	task automatic conclude;
		$display("checks=%0d mismatches=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input [15:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// pipeline plus model stage settle within five cycles
	task automatic meas(input signed [15:0] r);
		rawReq = r;
		tick(5);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
		tick(1);
	endtask
	// release wait covers the key synchroniser
	task automatic key(ref logic k, input int n);
		k = 1;
		tick(n);
		k = 0;
		tick(8);
	endtask
	task automatic add(input signed [15:0] x, y);
		pointX = x;
		pointY = y;
		pulse(pointAddFunc);
	endtask

	initial begin
		{setLowStb, setHighStb, dpEditActive, keyUpPin, keyDownPin, keyEnterPin} = 0;
		{pointAddFunc, pointDeleteFunc, pointEditFunc, pointAbort, pointStore} = 0;
		{rawReq, pointX, pointY, outputLowPoint, paramValue, inType, convShape} = 0;
		{lowExtensionPct, outLowExtPct, outputSourceSel, outVariant} = 0;
		highExtensionPct = 100; outHighExtPct = 50; outMode = 2; outputAlarmSel = 1;
		outputHighPoint = 1000; busValue = 500; pidOut = 300;
		tick(3);
		rst = 0;
		paramValue = 1000;
		pulse(setHighStb);
		tick(2);
		chk(displayHighValue, 1000);
		ev = '{500, 250, 707, 0, 0};
		for (int s = 0; s < 3; s++) begin
			convShape = 2'(s);
			meas(500);
			chk(displayValue, ev[s]);
		end
		convShape = 0;
		meas(500);
		chk(convOut, 10000);
		ev = '{0, 10000, 6000, 0, 0};
		for (int s = 1; s < 4; s++) begin
			outputSourceSel = 2'(s);
			tick(4);
			chk(aoutValue, ev[s]);
		end
		pidOut = -300;
		tick(4);
		chk(aoutValue, 6000);
		outputSourceSel = 0; outputLowPoint = 1000; outputHighPoint = 0;
		meas(250);
		chk(aoutValue, 15000);
		outputLowPoint = 0; outputHighPoint = 1000;
		meas(1050);
		chk(aoutValue, 21000);
		outHighExtPct = 20;
		tick(4);
		chk(aoutValue, 20400);
		outVariant = 2; outputSourceSel = 1;
		ev = '{2500, 3000, 5000, 6000, 0};
		for (int m = 3; m < 7; m++) begin
			outMode = 3'(m);
			tick(4);
			chk(aoutValue, ev[m - 3]);
		end
		busValue = 1200; outHighExtPct = 300; outMode = 5;
		tick(4);
		chk(aoutValue, 10990);
		outMode = 1;
		tick(4);
		chk(aoutEnable, 0);
		outVariant = 0; outMode = 2; outputSourceSel = 0;
		meas(1101);
		chk(overRangeWarning, 1);
		chk(aoutValue, 22100);
		outVariant = 2; outMode = 5;
		ev = '{11000, 5500, 1200, 600, 0};
		for (int a = 1; a < 6; a++) begin
			outputAlarmSel = 3'(a);
			tick(4);
			chk(aoutValue, ev[a - 1]);
		end
		meas(500);
		chk(aoutValue, 5000);
		outputAlarmSel = 0;
		meas(1101);
		chk(aoutValue, 5000);
		outVariant = 0; outMode = 2;
		meas(-1);
		chk(underRangeWarning, 1);
		inType = 1; lowExtensionPct = 100;
		meas(179);
		chk(underRangeWarning, 1);
		meas(180);
		chk(underRangeWarning, 0);
		inType = 0; lowExtensionPct = 0; paramValue = 10000;
		pulse(setHighStb);
		tick(2);
		chk(displayHighValue, 9999);
		meas(1050);
		chk(displayOverflowWarning, 1);
		paramValue = 1000;
		pulse(setHighStb);
		dpEditActive = 1;
		repeat (4) key(keyUpPin, 3);
		chk(decimalPos, 3);
		key(keyDownPin, 3);
		chk(decimalPos, 2);
		dpEditActive = 0; convShape = 3;
		tick(3);
		chk(tableErrorWarning, 1);
		add(0, 100);
		add(1000, 300);
		chk(pointCount, 2);
		add(1000, 5);
		chk(generalErrorWarning, 1);
		meas(500);
		chk(displayValue, 200);
		paramValue = 0;
		pulse(setLowStb);
		tick(2);
		chk(displayLowValue, 100);
		chk(displayHighValue, 300);
		for (int k = 1; k < 19; k++) add(16'(10 * k), 16'(k));
		add(1999, 0);
		chk(pointCount, 20);
		chk(generalErrorWarning, 1);
		pulse(pointDeleteFunc);
		chk(showPointCount, 1);
		tick(25);
		chk(showPointCount, 0);
		key(keyEnterPin, 3);
		chk(showCoordY, 1);
		key(keyEnterPin, 45);
		chk(deleteConfirmPrompt, 1);
		key(keyEnterPin, 3);
		chk(pointCount, 19);
		pulse(pointAbort);
		pulse(pointEditFunc);
		tick(25);
		chk(selX, 10);
		key(keyUpPin, 3);
		chk(selIndex, 1);
		chk(selX, 20);
		key(keyEnterPin, 45);
		chk(coordEditActive, 1);
		pointX = 500; pointY = 77;
		pulse(pointStore);
		tick(1);
		chk(selIndex, 17);
		chk(selX, 500);
		chk(selY, 77);
		chk(pointCount, 19);
		convShape = 0;
		tick(2);
		pulse(pointDeleteFunc);
		chk(showPointCount, 0);
		conclude();
	end
endmodule // testbench
